//--- include/ccy_pkg.sv
// ccy_pkg: register map, field positions, reset values and codes for the
// yuv capture block; assumes a 32-bit apb slave and 8-bit byte addresses
package ccy_pkg;
    localparam int AW = 8;
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] SUB_OFS   = 8'h04;
    localparam logic [7:0] HWIN_OFS  = 8'h08;
    localparam logic [7:0] VWIN_OFS  = 8'h0c;
    localparam logic [7:0] BASE_OFS  = 8'h10;
    localparam logic [7:0] PITCH_OFS = 8'h14;
    localparam logic [7:0] SHIFT_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS  = 8'h1c;
    // control register bits
    localparam int WEN_BIT   = 0;
    localparam int PACK_BIT  = 1;
    localparam int FMT_LSB   = 2;
    localparam int ESYNC_BIT = 4;
    localparam int EDGE_BIT  = 5;
    localparam int DINV_BIT  = 6;
    localparam int SWAP_BIT  = 7;
    localparam int CMSB_BIT  = 8;
    localparam int RSZ_BIT   = 9;
    localparam int COMP_BIT  = 10;
    localparam int CTRL_W    = 11;
    // line shift register fields
    localparam int EVEN0_LSB = 0;
    localparam int ODD0_LSB  = 3;
    localparam int EVEN1_LSB = 6;
    localparam int ODD1_LSB  = 9;
    localparam int FOFS_LSB  = 12;
    localparam int FINV_BIT  = 14;
    localparam int SHIFT_W   = 15;
    // reset values
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 11'h000;
    localparam logic [7:0]         SUB_RST   = 8'h00;
    localparam logic [31:0]        HWIN_RST  = 32'h0000_0000;
    localparam logic [31:0]        VWIN_RST  = 32'h0000_0000;
    localparam logic [31:0]        BASE_RST  = 32'h0000_0000;
    localparam logic [15:0]        PITCH_RST = 16'h0000;
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 15'h0000;
    // input format codes
    localparam logic [1:0] FMT_YUV16 = 2'h1;
    localparam logic [1:0] FMT_YUV8  = 2'h2;
    // embedded timing code and word address step
    localparam logic [7:0] CODE_FF = 8'hff;
    localparam logic [7:0] CODE_00 = 8'h00;
    localparam int F_BIT = 6;
    localparam int V_BIT = 5;
    localparam int H_BIT = 4;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
endpackage

//--- verilog/ccy_sync_dec.sv
// ccy_sync_dec: recovers blanking and field levels from timing codes
// ff 00 00 xy embedded in an 8-bit sample stream; runs on sample enables
`timescale 1ns/100ps
module ccy_sync_dec
    import ccy_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic [7:0] byte_i,
    output logic            code_o,
    output logic            h_o,
    output logic            v_o,
    output logic            f_o
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       h;
        logic       v;
        logic       f;
    } ccy_dec_t;

    ccy_dec_t s;
    ccy_dec_t n;

    always_comb begin
        n = s;
        if (en_i) begin
            case (s.cnt)
                2'h0: n.cnt = (byte_i == CODE_FF) ? 2'h1 : 2'h0;
                2'h1, 2'h2: begin
                    if (byte_i == CODE_00) begin
                        n.cnt = s.cnt + 2'h1;
                    end else begin
                        n.cnt = (byte_i == CODE_FF) ? 2'h1 : 2'h0;
                    end
                end
                default: begin
                    n.f   = byte_i[F_BIT];
                    n.v   = byte_i[V_BIT];
                    n.h   = byte_i[H_BIT];
                    n.cnt = 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // a preamble byte is never taken as picture data
    assign code_o = en_i && (s.cnt != 2'h0 || byte_i == CODE_FF);
    assign h_o    = s.h;
    assign v_o    = s.v;
    assign f_o    = s.f;
endmodule

//--- verilog/ccy_capture.sv
// ccy_capture: yuv capture path with apb registers, pixel clock sampling,
// input formatting, luma offset, framing window and line address control.
// assumes pixel clock and pins are asynchronous and far slower than clk_i.
`timescale 1ns/100ps
module ccy_capture
    import ccy_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic               pready_o,
    output logic               pslverr_o,
    output logic [31:0]        prdata_o,
    input  wire logic          pix_clk_i,
    input  wire logic [15:0]   pix_data_i,
    input  wire logic          hsync_i,
    input  wire logic          vsync_i,
    input  wire logic          field_i,
    output logic               wr_valid_o,
    output logic [31:0]        wr_addr_o,
    output logic [31:0]        wr_data_o,
    output logic               rsz_valid_o,
    output logic [15:0]        rsz_data_o,
    output logic               horizontal_sync_o,
    output logic               vertical_sync_o,
    output logic               field_o
);
    typedef struct packed {
        logic [2:0]         ck;
        logic [15:0]        d1;
        logic [15:0]        d2;
        logic [2:0]         p1;
        logic [2:0]         p2;
        logic [CTRL_W-1:0]  ctrl;
        logic [7:0]         sub;
        logic [31:0]        hwin;
        logic [31:0]        vwin;
        logic [31:0]        base;
        logic [15:0]        pitch;
        logic [SHIFT_W-1:0] shift;
        logic               rdy;
        logic               err;
        logic [31:0]        rdata;
        logic               hp;
        logic               vp;
        logic               fld;
        logic               pty;
        logic               ph;
        logic [15:0]        hcnt;
        logic [15:0]        vcnt;
        logic [31:0]        laddr;
        logic [31:0]        woff;
        logic [1:0]         lane;
        logic [31:0]        acc;
        logic               wv;
        logic [31:0]        wa;
        logic [31:0]        wd;
        logic               rv;
        logic [15:0]        rd;
        logic               hs;
        logic               vs;
        logic               fo;
    } ccy_st_t;

    ccy_st_t s;
    ccy_st_t n;

    // subtract with optional clip at zero
    function automatic logic [7:0] luma_sub(
        input logic [7:0] v,
        input logic [7:0] k,
        input logic       sat
    );
        logic [8:0] d;
        d = {1'b0, v} - {1'b0, k};
        luma_sub = (sat && d[8]) ? 8'h00 : d[7:0];
    endfunction

    // signed line offset: pitch times (code[1:0]+1), negative if code[2]
    function automatic logic [31:0] pitch_mul(
        input logic [15:0] p,
        input logic [2:0]  c
    );
        logic [31:0] m;
        m = 32'({16'h0000, p} * {30'h0, c[1:0]} + {16'h0000, p});
        pitch_mul = c[2] ? 32'(-m) : m;
    endfunction

    function automatic logic mapped(input logic [AW-1:0] a);
        mapped = a == CTRL_OFS || a == SUB_OFS || a == HWIN_OFS
              || a == VWIN_OFS || a == BASE_OFS || a == PITCH_OFS
              || a == SHIFT_OFS || a == STAT_OFS;
    endfunction

    // insert a byte or half word at the current lane
    function automatic logic [31:0] put(
        input logic [31:0] a,
        input logic [1:0]  ln,
        input logic        bm,
        input logic [15:0] u
    );
        logic [31:0] r;
        r = a;
        if (bm) begin
            r[ln*8 +: 8] = u[7:0];
        end else begin
            r[ln[1]*16 +: 16] = u;
        end
        put = r;
    endfunction

    logic        pix_en;
    logic [1:0]  fmt;
    logic        es;
    logic        yuv;
    logic        wide;
    logic [15:0] din;
    logic [15:0] dsw;
    logic [7:0]  yo;
    logic [7:0]  cval;
    logic [7:0]  s8;
    logic [15:0] unit;
    logic        bmode;
    logic        code;
    logic        dh;
    logic        dv;
    logic        df;
    logic        hb;
    logic        vb;
    logic        fi;
    logic        active;
    logic        lwin;
    logic        in_win;
    logic        full;
    logic [31:0] accm;
    logic [2:0]  stepc;
    logic [31:0] rdmux;

    assign pix_en = (s.ck[2] != s.ck[1])
                  && (s.ck[1] != s.ctrl[EDGE_BIT]);
    assign fmt  = s.ctrl[FMT_LSB +: 2];
    assign es   = s.ctrl[ESYNC_BIT];
    assign yuv  = fmt == FMT_YUV16 || fmt == FMT_YUV8 || es;
    assign wide = fmt == FMT_YUV16 && !es;
    assign din  = s.d2 ^ {16{s.ctrl[DINV_BIT]}};
    // with swap the upper half feeds the 8-bit path
    assign dsw  = s.ctrl[SWAP_BIT] ? {din[7:0], din[15:8]} : din;
    // clip only in 16-bit mode
    assign yo   = luma_sub(wide ? dsw[15:8] : dsw[7:0], s.sub,
                           wide);
    assign cval = (wide ? dsw[7:0] : dsw[7:0])
                ^ {s.ctrl[CMSB_BIT], 7'h00};
    // 8-bit stream order is cb y cr y, chroma first after each line
    assign s8   = s.ph ? yo : cval;
    assign unit = wide ? {yo, cval} : {8'h00, s8};
    assign bmode = s.ctrl[PACK_BIT] && (!wide || s.ctrl[COMP_BIT]);

    ccy_sync_dec u_dec (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (pix_en && es),
        .byte_i  (dsw[7:0]),
        .code_o  (code),
        .h_o     (dh),
        .v_o     (dv),
        .f_o     (df)
    );

    assign hb     = es ? dh : s.p2[2];
    assign vb     = es ? dv : s.p2[1];
    assign fi     = es ? df : s.p2[0];
    assign active = !hb && !vb && !code;
    assign lwin   = s.vcnt >= s.vwin[15:0]
                  && {1'b0, s.vcnt}
                     < {1'b0, s.vwin[15:0]} + {1'b0, s.vwin[31:16]};
    assign in_win = lwin && s.hcnt >= s.hwin[15:0]
                  && {1'b0, s.hcnt}
                     < {1'b0, s.hwin[15:0]} + {1'b0, s.hwin[31:16]};
    assign accm = put(s.acc, s.lane, bmode, unit);
    assign full = bmode ? s.lane == 2'h3 : s.lane[1];

    // step chosen by latched field id and line parity
    always_comb begin
        case ({s.fld ^ s.shift[FINV_BIT], s.pty})
            2'b00:   stepc = s.shift[EVEN0_LSB +: 3];
            2'b01:   stepc = s.shift[ODD0_LSB +: 3];
            2'b10:   stepc = s.shift[EVEN1_LSB +: 3];
            default: stepc = s.shift[ODD1_LSB +: 3];
        endcase
    end

    always_comb begin
        case (paddr_i)
            CTRL_OFS:  rdmux = {21'h0, s.ctrl};
            SUB_OFS:   rdmux = {24'h0, s.sub};
            HWIN_OFS:  rdmux = s.hwin;
            VWIN_OFS:  rdmux = s.vwin;
            BASE_OFS:  rdmux = s.base;
            PITCH_OFS: rdmux = {16'h0, s.pitch};
            SHIFT_OFS: rdmux = {17'h0, s.shift};
            STAT_OFS:  rdmux = {12'h0, vb, hb, yuv, s.fld, s.vcnt};
            default:   rdmux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        n    = s;
        n.ck = {s.ck[1:0], pix_clk_i};
        n.d1 = pix_data_i;
        n.d2 = s.d1;
        n.p1 = {hsync_i, vsync_i, field_i};
        n.p2 = s.p1;
        n.wv = 1'b0;
        n.rv = 1'b0;
        n.hs = yuv && hb;
        n.vs = yuv && vb;
        n.fo = yuv && fi;
        // one wait state: pready rises in the second access cycle
        if (psel_i && penable_i && !s.rdy) begin
            n.rdy   = 1'b1;
            n.err   = !mapped(paddr_i);
            n.rdata = rdmux;
        end else begin
            n.rdy = 1'b0;
            n.err = 1'b0;
        end
        if (psel_i && penable_i && s.rdy && pwrite_i) begin
            case (paddr_i)
                CTRL_OFS:  n.ctrl  = pwdata_i[CTRL_W-1:0];
                SUB_OFS:   n.sub   = pwdata_i[7:0];
                HWIN_OFS:  n.hwin  = pwdata_i;
                VWIN_OFS:  n.vwin  = pwdata_i;
                BASE_OFS:  n.base  = pwdata_i;
                PITCH_OFS: n.pitch = pwdata_i[15:0];
                SHIFT_OFS: n.shift = pwdata_i[SHIFT_W-1:0];
                default:   n.ctrl  = s.ctrl;
            endcase
        end
        if (pix_en && yuv) begin
            n.hp = hb;
            n.vp = vb;
            if (s.vp && !vb) begin
                n.vcnt  = 16'h0000;
                n.fld   = fi;
                n.pty   = 1'b0;
                n.woff  = 32'h0000_0000;
                n.lane  = 2'h0;
                // field 1 starts shifted forward by the field line shift; with FINV_BIT set, field 0 starts shifted backward
                n.laddr = s.base + ((fi ^ s.shift[FINV_BIT])
                    ? pitch_mul(s.pitch, {s.shift[FINV_BIT],
                                          s.shift[FOFS_LSB +: 2]})
                    : 32'h0000_0000);
            end else if (hb && !s.hp) begin
                n.hcnt = 16'h0000;
                n.ph   = 1'b0;
                n.lane = 2'h0;
                if (!vb) begin
                    n.vcnt = s.vcnt + 16'h0001;
                    if (lwin) begin
                        n.laddr = s.laddr
                                + pitch_mul(s.pitch, stepc);
                        n.pty   = ~s.pty;
                        n.woff  = 32'h0000_0000;
                    end
                end
            end
            if (active) begin
                n.hcnt = s.hcnt + 16'h0001;
                n.ph   = ~s.ph;
                if (in_win) begin
                    n.rv  = s.ctrl[RSZ_BIT];
                    n.rd  = unit;
                    n.acc = accm;
                    if (full) begin
                        n.wv   = s.ctrl[WEN_BIT];
                        n.wa   = s.laddr + s.woff;
                        n.wd   = accm;
                        n.woff = s.woff + WORD_STEP;
                        n.lane = 2'h0;
                        n.acc  = 32'h0000_0000;
                    end else begin
                        n.lane = bmode ? s.lane + 2'h1
                                       : s.lane + 2'h2;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s       <= '0;
            s.ctrl  <= CTRL_RST;
            s.sub   <= SUB_RST;
            s.hwin  <= HWIN_RST;
            s.vwin  <= VWIN_RST;
            s.base  <= BASE_RST;
            s.pitch <= PITCH_RST;
            s.shift <= SHIFT_RST;
        end else begin
            s <= n;
        end
    end

    assign pready_o          = s.rdy;
    assign pslverr_o         = s.err;
    assign prdata_o          = s.rdata;
    assign wr_valid_o        = s.wv;
    assign wr_addr_o         = s.wa;
    assign wr_data_o         = s.wd;
    assign rsz_valid_o       = s.rv;
    assign rsz_data_o        = s.rd;
    assign horizontal_sync_o = s.hs;
    assign vertical_sync_o   = s.vs;
    assign field_o           = s.fo;
endmodule

//--- verification/ccy_capture_monitor.sv
// ccy_capture_monitor: port level assertions for the yuv capture block.
// assumes it is bound to ccy_capture and sees only that module's ports.
`timescale 1ns/100ps
module ccy_capture_monitor
    import ccy_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          psel_i,
    input wire logic          penable_i,
    input wire logic          pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0]   pwdata_i,
    input wire logic          pready_o,
    input wire logic          pslverr_o,
    input wire logic [31:0]   prdata_o,
    input wire logic          wr_valid_o,
    input wire logic [31:0]   wr_addr_o,
    input wire logic [31:0]   wr_data_o,
    input wire logic          rsz_valid_o,
    input wire logic          horizontal_sync_o,
    input wire logic          vertical_sync_o,
    input wire logic          field_o
);
    logic [CTRL_W-1:0] ctl_r;
    logic [31:0]       last_r;
    logic              seen_r;
    logic              brk_r;
    logic              yuv;
    assign yuv = ctl_r[FMT_LSB+:2] == FMT_YUV16 ||
                 ctl_r[FMT_LSB+:2] == FMT_YUV8 || ctl_r[ESYNC_BIT];
    // shadow of the control word, taken at the edge the write lands
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_r  <= '0;
            last_r <= '0;
            seen_r <= 1'b0;
            brk_r  <= 1'b0;
        end else begin
            if (psel_i && penable_i && pready_o && pwrite_i &&
                !pslverr_o && paddr_i == CTRL_OFS)
                ctl_r <= pwdata_i[CTRL_W-1:0];
            if (wr_valid_o) begin
                last_r <= wr_addr_o;
                seen_r <= 1'b1;
                brk_r  <= 1'b0;
            end else if (horizontal_sync_o || vertical_sync_o || !yuv)
                brk_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_after_access: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access phase not answered in one cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (
        pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error without ready or with data");
    a_write_gated: assert property (
        wr_valid_o |-> ctl_r[WEN_BIT])
        else $error("memory write while writes disabled");
    a_path_off_quiet: assert property (
        !yuv |-> !wr_valid_o && !rsz_valid_o)
        else $error("output while yuv path is off");
    a_sync_off_low: assert property (
        !yuv [*3] |-> !horizontal_sync_o && !vertical_sync_o && !field_o)
        else $error("sync outputs active while yuv path is off");
    a_rsz_gated: assert property (
        rsz_valid_o |-> ctl_r[RSZ_BIT])
        else $error("resizer sample while resizer path off");
    a_unpacked_zero: assert property (
        wr_valid_o && ctl_r[FMT_LSB+:2] == FMT_YUV8 && !ctl_r[PACK_BIT]
        |-> wr_data_o[31:24] == 8'h00 && wr_data_o[15:8] == 8'h00)
        else $error("unpacked word upper byte not zero");
    a_word_step: assert property (
        wr_valid_o && seen_r && !brk_r |-> wr_addr_o == last_r + WORD_STEP)
        else $error("word address inside a line did not step by four");
    a_wr_pulse: assert property (wr_valid_o |=> !wr_valid_o [*4])
        else $error("write strobe too long or too close");
endmodule
bind ccy_capture ccy_capture_monitor u_mon (.*);

//--- verification/ccy_src_model.sv
// ccy_src_model: behavioural yuv source, one 3-line frame per go pulse.
// assumes the bench holds seed, edge and field steady during a frame.
`timescale 1ns/100ps
module ccy_src_model (
    input  wire logic        go_i,
    input  wire logic [7:0]  seed_i,
    input  wire logic        fall_i,
    input  wire logic        fld_i,
    input  wire logic        emb_i,
    output logic             busy_o,
    output logic             pix_clk_o,
    output logic [15:0]      pix_data_o,
    output logic             hsync_o,
    output logic             vsync_o,
    output logic             field_o
);
    logic ck = 1'b0;
    // pins move on the non-sampling edge so they stand 80 ns either side
    assign pix_clk_o = ck ^ fall_i;
    initial begin
        busy_o     = 1'b0;
        pix_data_o = 16'h0000;
        hsync_o    = 1'b1;
        vsync_o    = 1'b1;
        field_o    = 1'b0;
    end
    task automatic cyc(input logic h, input logic v, input logic [15:0] d);
        ck = 1'b0;
        hsync_o = h;
        vsync_o = v;
        pix_data_o = d;
        #80 ck = 1'b1;
        #80;
    endtask
    // embedded mode sends an end code (then a start code) per blank gap
    task automatic seg(input logic v, input logic sav);
        if (!emb_i) repeat (2) cyc(1'b1, v, ~pix_data_o);
        for (int h = 1; emb_i && h >= int'(!sav); h--) begin
            cyc(1'b1, v, 16'h00ff);
            repeat (2) cyc(1'b1, v, 16'h0000);
            cyc(1'b1, v, {9'h001, field_o, v, 1'(h), 4'h0});
        end
    endtask
    // clock stands still between frames; blank data is the inverse of last
    always @(posedge go_i) begin
        busy_o = 1'b1;
        field_o = fld_i;
        seg(1'b1, 1'b0);
        for (int l = 0; l < 3; l++) begin
            seg(1'b0, 1'b1);
            for (int k = 0; k < 6; k++)
                cyc(1'b0, 1'b0, {seed_i + 8'(3 * k), 8'(8'h70 + k + 16 * l)});
        end
        seg(1'b0, 1'b0);
        seg(1'b1, 1'b0);
        busy_o = 1'b0;
    end
endmodule

//--- verification/ccy_capture_tb_top.sv
// ccy_capture_tb_top: register and frame capture tests of ccy_capture.
// assumes ccy_src_model as the video source and the bound monitor.
`timescale 1ns/100ps
module ccy_capture_tb_top;
    import ccy_pkg::*;
    localparam logic [31:0] BASE = 32'h1000;
    localparam logic [31:0] PITCH = 32'h40;
    localparam logic [31:0] MSK [7] = '{32'h7ff, 32'hff, 32'hffff_ffff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff, 32'h7fff};
    // compression stays off in every setup
    localparam logic [31:0] CTL [7] = '{32'h205, 32'h1e5, 32'h189,
        32'h20b, 32'h004, 32'h201, 32'h211};
    localparam logic [14:0] SHF [7] = '{15'h0, 15'h4b6d, 15'h1249,
        15'h0, 15'h0, 15'h0, 15'h1249};
    localparam logic [6:0] FLD = 7'b1000100;
    logic          clk_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          psel_i = 1'b0;
    logic          penable_i = 1'b0;
    logic          pwrite_i = 1'b0;
    logic [AW-1:0] paddr_i = '0;
    logic [31:0]   pwdata_i = '0;
    logic [31:0]   prdata_o, wr_addr_o, wr_data_o, lf = 32'd92799, q;
    logic          pready_o, pslverr_o, wr_valid_o, rsz_valid_o;
    logic [15:0]   pix_data_i, rsz_data_o;
    logic          pix_clk_i, hsync_i, vsync_i, field_i;
    logic          horizontal_sync_o, vertical_sync_o, field_o;
    logic          go = 1'b0, fall = 1'b0, fld = 1'b0, busy;
    logic          emb = 1'b0;
    logic [15:0]   rq [$];
    logic [7:0]    seed = 8'h00;
    logic [63:0]   eq [$];
    logic [63:0]   x;
    int            miscompares = 0, check_count = 0, rszc = 0, cyc = 0;
    ccy_capture dut (.*);
    ccy_src_model src (.go_i(go), .seed_i(seed), .fall_i(fall),
        .fld_i(fld), .emb_i(emb), .busy_o(busy), .pix_clk_o(pix_clk_i),
        .pix_data_o(pix_data_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
        .field_o(field_i));
    always #10 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] e,
                         input string m);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 40000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // processed sample: {y,c} in 16-bit mode, {00,sample} in 8-bit mode
    function automatic logic [15:0] smp(input logic [31:0] c,
        input logic [7:0] sb, input logic [7:0] s, input int l, input int k);
        logic [15:0] r;
        logic [7:0] b;
        r = {s + 8'(3 * k), 8'(8'h70 + k + 16 * l)};
        if (c[DINV_BIT]) r = ~r;
        if (c[SWAP_BIT]) r = {r[7:0], r[15:8]};
        if (c[FMT_LSB+:2] == FMT_YUV16) begin
            if (c[CMSB_BIT]) r[7] = ~r[7];
            r[15:8] = (r[15:8] < sb) ? 8'h00 : r[15:8] - sb;
            return r;
        end
        b = r[7:0];
        if (k % 2 == 0 && c[CMSB_BIT]) b[7] = ~b[7];
        if (k % 2 == 1) b = b - sb;
        return {8'h00, b};
    endfunction
    task automatic frame(input logic [31:0] c, input logic [14:0] sh,
                         input logic f, input logic z);
        logic [31:0] a, d;
        logic [15:0] p0, p1, p2, p3;
        logic [7:0] s, sb;
        logic [2:0] cd;
        logic pk, ff, on;
        int i, j, k, n;
        lf = lfsr(lf);
        s = {1'b0, lf[6:0]};
        sb = z ? 8'h00 : s + 8'd10;
        w(CTRL_OFS, c);
        w(SUB_OFS, {24'h0, sb});
        w(SHIFT_OFS, {17'h0, sh});
        seed <= s;
        fall <= c[EDGE_BIT];
        fld <= f;
        emb <= c[ESYNC_BIT];
        pk = c[PACK_BIT];
        ff = f ^ sh[FINV_BIT];
        on = c[FMT_LSB+:2] == FMT_YUV16 || c[FMT_LSB+:2] == FMT_YUV8
             || c[ESYNC_BIT];
        n = sh[FOFS_LSB+:2] + 1;
        a = !ff ? BASE : sh[FINV_BIT] ? BASE - 32'(n) * PITCH
                                      : BASE + 32'(n) * PITCH;
        eq.delete();
        rq.delete();
        for (i = 0; i < 2 && on; i++) begin
            for (k = 2; k < 6 && c[RSZ_BIT]; k++)
                rq.push_back(smp(c, sb, s, i + 1, k));
            for (j = 0; j < (pk ? 1 : 2) && c[WEN_BIT]; j++) begin
                k = 2 + (pk ? 4 : 2) * j;
                p0 = smp(c, sb, s, i + 1, k);
                p1 = smp(c, sb, s, i + 1, k + 1);
                p2 = smp(c, sb, s, i + 1, k + 2);
                p3 = smp(c, sb, s, i + 1, k + 3);
                d = pk ? {p3[7:0], p2[7:0], p1[7:0], p0[7:0]} : {p1, p0};
                eq.push_back({a + 32'(4 * j), d});
            end
            cd = sh[(ff ? (i % 2 ? ODD1_LSB : EVEN1_LSB)
                        : (i % 2 ? ODD0_LSB : EVEN0_LSB)) +: 3];
            n = cd[1:0] + 1;
            a = cd[2] ? a - 32'(n) * PITCH : a + 32'(n) * PITCH;
        end
        rszc = 0;
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        while (busy === 1'b1) begin
            @(posedge clk_i);
        end
        repeat (10) @(posedge clk_i);
        check({29'h0, horizontal_sync_o, vertical_sync_o, field_o},
              on ? {29'h0, 2'h3, f} : 32'h0, "sync");
        check(32'(eq.size()), 32'h0, "missing writes");
        check(32'(rszc), (c[RSZ_BIT] && on) ? 8 : 0, "resizer");
    endtask
    always @(posedge clk_i) begin
        if (rsz_valid_o === 1'b1) begin
            rszc++;
            if (rq.size() > 0)
                check(32'(rsz_data_o), 32'(rq.pop_front()), "rsz");
        end
        if (wr_valid_o === 1'b1) begin
            if (eq.size() == 0) check(32'h0, 32'h1, "extra write");
            else begin
                x = eq.pop_front();
                check(wr_addr_o, x[63:32], "addr");
                check(wr_data_o, x[31:0], "data");
            end
        end
    end
    initial begin : main
        int i;
        logic e;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            check(q, 32'h0, "reset value");
            lf = lfsr(lf);
            w(8'(4 * i), lf);
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            check(q, lf & MSK[i], "readback");
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped data");
        w(HWIN_OFS, 32'h0004_0002);
        w(VWIN_OFS, 32'h0002_0001);
        w(BASE_OFS, BASE);
        w(PITCH_OFS, PITCH);
        for (i = 0; i < 7; i++) frame(CTL[i], SHF[i], FLD[i], i == 3);
        final_report();
    end
endmodule
